// *** i2c_master_controller.sv ***
// master-only two-wire byte controller with plain control and status ports
`default_nettype none

module i2c_master_controller #(
    parameter int unsigned div_width = i2c_master_defs::div_width
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [div_width-1:0] clock_divider_value,
    input wire logic start_request,
    input wire logic stop_request,
    input wire logic controller_enable,
    input wire logic ack_send_control,
    input wire logic [7:0] tx_data,
    input wire logic tx_write,
    input wire logic rx_read,
    output logic [7:0] rx_data,
    output logic op_complete_flag,
    output logic ack_received_flag,
    output logic rx_byte_ready_flag,
    output logic bus_owned,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe
);
    // ==================================================================
    // state record
    typedef struct packed {
        i2c_master_defs::seq_state_type st;
        logic [1:0] step;
        logic [2:0] bitn;
        logic [7:0] shreg;
        logic [7:0] rxdata;
        logic complete;
        logic ackrx;
        logic rxready;
        logic owned;
        logic read_mode;
        logic is_addr;
        logic do_ack;
        logic scl;
        logic sda;
        logic sda_s1;
        logic sda_s2;
    } ctrl_state_type;

    ctrl_state_type cur;
    ctrl_state_type next_cur;
    logic tick;
    logic running;

    // ==================================================================
    // half-period timing
    assign running = (cur.st != i2c_master_defs::st_idle);

    i2c_half_tick #(
        .width(div_width)
    ) half_tick (
        .mclk(mclk),
        .rst(rst),
        .run(running),
        .divider(clock_divider_value),
        .tick(tick)
    );

    // ==================================================================
    // sequencer
    always_comb begin
        next_cur = cur;
        next_cur.sda_s1 = sda_in;
        next_cur.sda_s2 = cur.sda_s1;
        // software read of receive data clears the flag; a new byte wins below
        if (rx_read) begin
            next_cur.rxready = 1'b0;
        end
        case (cur.st)
            i2c_master_defs::st_idle: begin
                if (!controller_enable && !cur.owned) begin
                    next_cur.scl = i2c_master_defs::line_released;
                    next_cur.sda = i2c_master_defs::line_released;
                end
                if (tx_write && controller_enable) begin
                    next_cur.complete = 1'b0;
                    next_cur.shreg = tx_data;
                    next_cur.bitn = '0;
                    next_cur.do_ack = ack_send_control;
                    next_cur.is_addr = 1'b0;
                    if (stop_request) begin
                        next_cur.st = i2c_master_defs::st_stop;
                        next_cur.step = i2c_master_defs::step_low;
                    end else if (start_request) begin
                        next_cur.st = i2c_master_defs::st_start;
                        next_cur.is_addr = 1'b1;
                        // owned bus needs a repeated start from a low clock
                        next_cur.step = cur.owned ? i2c_master_defs::step_low
                                                  : i2c_master_defs::step_high;
                    end else begin
                        next_cur.st = i2c_master_defs::st_bits;
                        next_cur.step = i2c_master_defs::step_low;
                    end
                end
            end
            i2c_master_defs::st_start: begin
                if (tick) begin
                    case (cur.step)
                        i2c_master_defs::step_low: begin
                            next_cur.scl = i2c_master_defs::line_released;
                            next_cur.sda = i2c_master_defs::line_released;
                            next_cur.step = i2c_master_defs::step_high;
                        end
                        i2c_master_defs::step_high: begin
                            next_cur.scl = i2c_master_defs::line_released;
                            next_cur.sda = i2c_master_defs::line_low;
                            next_cur.owned = 1'b1;
                            next_cur.step = i2c_master_defs::step_edge;
                        end
                        default: begin
                            next_cur.scl = i2c_master_defs::line_low;
                            next_cur.st = i2c_master_defs::st_bits;
                            next_cur.step = i2c_master_defs::step_low;
                        end
                    endcase
                end else if (cur.step == i2c_master_defs::step_low) begin
                    next_cur.scl = i2c_master_defs::line_low;
                    next_cur.sda = i2c_master_defs::line_released;
                end
            end
            i2c_master_defs::st_bits: begin
                if (cur.step == i2c_master_defs::step_low) begin
                    next_cur.scl = i2c_master_defs::line_low;
                    // reading releases data so the slave can drive it
                    next_cur.sda = (cur.read_mode && !cur.is_addr)
                                   ? i2c_master_defs::line_released
                                   : cur.shreg[7];
                    if (tick) begin
                        next_cur.step = i2c_master_defs::step_high;
                        next_cur.scl = i2c_master_defs::line_released;
                    end
                end else if (tick) begin
                    next_cur.scl = i2c_master_defs::line_low;
                    next_cur.shreg = {cur.shreg[6:0], cur.sda_s2};
                    next_cur.bitn = cur.bitn + 1'b1;
                    next_cur.step = i2c_master_defs::step_low;
                    if (cur.bitn == i2c_master_defs::last_bit) begin
                        next_cur.st = i2c_master_defs::st_ack;
                    end
                end
            end
            i2c_master_defs::st_ack: begin
                if (cur.step == i2c_master_defs::step_low) begin
                    next_cur.scl = i2c_master_defs::line_low;
                    if (cur.read_mode && !cur.is_addr) begin
                        next_cur.sda = cur.do_ack ? i2c_master_defs::line_low
                                                  : i2c_master_defs::line_released;
                    end else begin
                        next_cur.sda = i2c_master_defs::line_released;
                    end
                    if (tick) begin
                        next_cur.step = i2c_master_defs::step_high;
                        next_cur.scl = i2c_master_defs::line_released;
                    end
                end else if (tick) begin
                    next_cur.scl = i2c_master_defs::line_low;
                    next_cur.st = i2c_master_defs::st_idle;
                    next_cur.step = i2c_master_defs::step_low;
                    next_cur.complete = 1'b1;
                    if (cur.read_mode && !cur.is_addr) begin
                        next_cur.rxdata = cur.shreg;
                        next_cur.rxready = 1'b1;
                    end else begin
                        next_cur.ackrx = (cur.sda_s2 == i2c_master_defs::line_low);
                    end
                    if (cur.is_addr) begin
                        // sampled copy of the sent byte keeps its bit order
                        next_cur.read_mode = cur.shreg[i2c_master_defs::dir_bit];
                    end
                end
            end
            i2c_master_defs::st_stop: begin
                if (!cur.owned) begin
                    // nothing to release: finish at once
                    next_cur.st = i2c_master_defs::st_idle;
                    next_cur.complete = 1'b1;
                end else if (tick) begin
                    case (cur.step)
                        i2c_master_defs::step_low: begin
                            next_cur.scl = i2c_master_defs::line_released;
                            next_cur.step = i2c_master_defs::step_high;
                        end
                        default: begin
                            next_cur.sda = i2c_master_defs::line_released;
                            next_cur.owned = 1'b0;
                            next_cur.read_mode = 1'b0;
                            next_cur.st = i2c_master_defs::st_idle;
                            next_cur.complete = 1'b1;
                        end
                    endcase
                end else if (cur.step == i2c_master_defs::step_low) begin
                    next_cur.scl = i2c_master_defs::line_low;
                    next_cur.sda = i2c_master_defs::line_low;
                end
            end
            default: begin
                next_cur.st = i2c_master_defs::st_idle;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur <= '0;
            cur.st <= i2c_master_defs::st_idle;
            cur.complete <= 1'b1;
            cur.scl <= i2c_master_defs::line_released;
            cur.sda <= i2c_master_defs::line_released;
            cur.sda_s1 <= 1'b1;
            cur.sda_s2 <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // ==================================================================
    // outputs; open-drain, so only the low level is ever driven
    assign rx_data = cur.rxdata;
    assign op_complete_flag = cur.complete;
    assign ack_received_flag = cur.ackrx;
    assign rx_byte_ready_flag = cur.rxready;
    assign bus_owned = cur.owned;
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    assign sda_oe = ~cur.sda;
    assign scl_oe = ~cur.scl;
endmodule : i2c_master_controller

`default_nettype wire

// *** i2c_master_defs.sv ***
// constants, states and bit-clock divider of the two-wire master
`default_nettype none

package i2c_master_defs;
    // ==================================================================
    // clock and rate figures
    localparam int unsigned mclk_hz = 25_000_000;
    localparam int unsigned standard_rate_bps = 100_000;
    localparam int unsigned fast_rate_bps = 400_000;
    // least divider value keeping the line within each mode's rate
    localparam int unsigned standard_min_div =
        (mclk_hz + 2 * standard_rate_bps - 1) / (2 * standard_rate_bps) - 1;
    localparam int unsigned fast_min_div =
        (mclk_hz + 2 * fast_rate_bps - 1) / (2 * fast_rate_bps) - 1;
    localparam int unsigned div_width = 8;
    localparam logic [div_width-1:0] div_reset = 8'h7c;

    // ==================================================================
    // byte and phase layout
    localparam int unsigned byte_width = 8;
    localparam logic [2:0] last_bit = 3'h7;
    localparam int unsigned dir_bit = 0;
    localparam logic [1:0] step_low = 2'h0;
    localparam logic [1:0] step_high = 2'h1;
    localparam logic [1:0] step_edge = 2'h2;
    localparam logic line_released = 1'b1;
    localparam logic line_low = 1'b0;

    // ==================================================================
    // sequencer states, gray along idle-start-bits-ack path
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_start = 3'b001,
        st_bits = 3'b011,
        st_ack = 3'b010,
        st_stop = 3'b110
    } seq_state_type;
endpackage : i2c_master_defs

// ==================================================================
// half-period tick: one pulse every (divider+1) cycles while running
module i2c_half_tick #(
    parameter int unsigned width = i2c_master_defs::div_width
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic [width-1:0] divider,
    output logic tick
);
    typedef struct packed {
        logic [width-1:0] count;
        logic tick;
    } tick_state_type;

    tick_state_type cur;
    tick_state_type next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        // restart from zero when idle so every phase starts full length
        if (!run) begin
            next_cur.count = '0;
        end else if (cur.count >= divider) begin
            next_cur.count = '0;
            next_cur.tick = 1'b1;
        end else begin
            next_cur.count = cur.count + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign tick = cur.tick;
endmodule : i2c_half_tick

`default_nettype wire

// *** i2c_master_controller_checker.sv ***
// port assertions for the two-wire master
`default_nettype none

module i2c_master_controller_checker #(
    parameter int unsigned div_width = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [div_width-1:0] clock_divider_value,
    input wire logic start_request,
    input wire logic stop_request,
    input wire logic controller_enable,
    input wire logic ack_send_control,
    input wire logic [7:0] tx_data,
    input wire logic tx_write,
    input wire logic rx_read,
    input wire logic [7:0] rx_data,
    input wire logic op_complete_flag,
    input wire logic ack_received_flag,
    input wire logic rx_byte_ready_flag,
    input wire logic bus_owned,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic scl_out,
    input wire logic scl_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ==================================================================
    // length of each released line-clock phase; start and stop move data inside it
    logic [15:0] run;
    logic moved;
    logic prev_scl;
    logic prev_sda;
    always_ff @(posedge mclk) begin
        prev_scl <= scl_oe;
        prev_sda <= sda_oe;
        if (rst || scl_oe != prev_scl) begin
            run <= 16'h1;
            moved <= 1'b0;
        end else begin
            run <= run + 16'h1;
            moved <= moved | (sda_oe != prev_sda);
        end
    end
    // ==================================================================
    // assertions
    AST_RESET_STATE: assert property ($fell(rst) |-> op_complete_flag && !ack_received_flag
        && !rx_byte_ready_flag && !sda_oe && !scl_oe) else $error("state after reset wrong");
    AST_WRITE_CLEARS: assert property (tx_write && controller_enable && op_complete_flag
        |=> !op_complete_flag) else $error("accepted write left complete high");
    AST_DISABLED_IGNORED: assert property (tx_write && !controller_enable && op_complete_flag
        |=> op_complete_flag && !bus_owned) else $error("write acted while disabled");
    AST_COMPLETE_HOLDS: assert property (op_complete_flag && !(tx_write && controller_enable)
        |=> op_complete_flag) else $error("complete dropped without a write");
    AST_LINE_CLOCK: assert property ($rose(scl_oe) && !moved
        |-> run == 16'(clock_divider_value) + 16'h1) else $error("line clock phase length wrong");
    AST_RX_WITH_DONE: assert property ($rose(rx_byte_ready_flag)
        |-> $rose(op_complete_flag)) else $error("received flag rose outside completion");
    AST_RX_CLEAR: assert property (rx_read && op_complete_flag |=> !rx_byte_ready_flag)
        else $error("read did not clear received flag");
    AST_ACK_ON_DONE: assert property ($changed(ack_received_flag)
        |-> $rose(op_complete_flag)) else $error("ack flag moved outside completion");
    AST_IDLE_RELEASED: assert property (op_complete_flag && !bus_owned
        |-> !sda_oe && !scl_oe) else $error("idle bus not released");
    AST_OPEN_DRAIN: assert property (!sda_out && !scl_out)
        else $error("line driven high");
    cover property ($rose(rx_byte_ready_flag));
    cover property ($rose(ack_received_flag));
    cover property ($fell(bus_owned));
endmodule : i2c_master_controller_checker

bind i2c_master_controller i2c_master_controller_checker #(.div_width(div_width)) i_checker (
    .mclk, .rst, .clock_divider_value, .start_request, .stop_request, .controller_enable,
    .ack_send_control, .tx_data, .tx_write, .rx_read, .rx_data, .op_complete_flag,
    .ack_received_flag, .rx_byte_ready_flag, .bus_owned, .sda_in, .sda_out, .sda_oe,
    .scl_out, .scl_oe);
`default_nettype wire

// *** eeprom_slave_model.sv ***
// behavioural serial memory slave on the two-wire bus
`default_nettype none

module eeprom_slave_model #(
    parameter logic [6:0] dev_addr = 7'h50
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] ptr;
    logic [7:0] sh;
    logic [7:0] rb;
    int bitn;
    int phase; // 0 address, 1 word, 2 data, 3 read, 4 idle
    initial begin
        sda_pull = 1'b0;
        phase = 4;
        bitn = 0;
        ptr = 8'h00;
        foreach (mem[i]) mem[i] = 8'(i) ^ 8'ha5;
    end
    always @(negedge sda) if (scl === 1'b1) begin
        phase = 0;
        bitn = 0;
    end
    always @(posedge sda) if (scl === 1'b1) phase = 4;
    always @(posedge scl) begin
        if (bitn < 8) sh = {sh[6:0], sda};
        else if (phase == 3 && sda) phase = 4;
        bitn++;
    end
    // changes only while the clock is low, so never a false start or stop
    always @(negedge scl) begin
        if (bitn == 9) begin
            bitn = 0;
            if (phase == 3) begin
                rb = mem[ptr];
                ptr++;
            end
        end
        if (bitn == 8) begin
            sda_pull = phase == 1 || phase == 2 || (phase == 0 && sh[7:1] == dev_addr);
            if (phase == 2) begin
                mem[ptr] = sh;
                ptr++;
            end
            if (phase == 1) begin
                ptr = sh;
                phase = 2;
            end
            if (phase == 0) phase = (sh[7:1] != dev_addr) ? 4 : (sh[0] ? 3 : 1);
        end else begin
            sda_pull = phase == 3 && !rb[7 - bitn];
        end
    end
endmodule : eeprom_slave_model
`default_nettype wire

// *** i2c_master_controller_tb.sv ***
// self-checking bench for the two-wire master against a memory slave
`default_nettype none

module i2c_master_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] mem_addr = 7'h50;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] clock_divider_value = 8'(i2c_master_defs::fast_min_div);
    logic start_request = 1'b0;
    logic stop_request = 1'b0;
    logic controller_enable = 1'b0;
    logic ack_send_control = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic tx_write = 1'b0;
    logic rx_read = 1'b0;
    logic [7:0] rx_data;
    logic op_complete_flag, ack_received_flag, rx_byte_ready_flag, bus_owned;
    logic sda_out, sda_oe, scl_out, scl_oe, sda_pull, sda_wire, scl_wire;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    // both lines have pull-ups
    assign sda_wire = (sda_oe || sda_pull) ? 1'b0 : 1'b1;
    assign scl_wire = scl_oe ? 1'b0 : 1'b1;
    always #20 mclk = ~mclk;
    i2c_master_controller i_i2c_master_controller (.mclk, .rst, .clock_divider_value,
        .start_request, .stop_request, .controller_enable, .ack_send_control, .tx_data,
        .tx_write, .rx_read, .rx_data, .op_complete_flag, .ack_received_flag,
        .rx_byte_ready_flag, .bus_owned, .sda_in(sda_wire), .sda_out, .sda_oe, .scl_out, .scl_oe);
    eeprom_slave_model i_eeprom_slave_model (.scl(scl_wire), .sda(sda_wire), .sda_pull);
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    // the whole run needs about 15500 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            finish_test();
        end
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic do_byte(input logic [7:0] d, input logic st, input logic sp, input logic ak);
        int n;
        n = 0;
        @(posedge mclk);
        controller_enable <= 1'b1;
        start_request <= st;
        stop_request <= sp;
        ack_send_control <= ak;
        tx_data <= d;
        tx_write <= 1'b1;
        @(posedge mclk);
        tx_write <= 1'b0;
        #1;
        check("busy after write", op_complete_flag, 1'b0);
        while (op_complete_flag !== 1'b1 && n < 8000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("complete", op_complete_flag, 1'b1);
    endtask : do_byte
    task automatic read_byte(input logic [7:0] exp, input logic ak);
        do_byte(8'hff, 1'b0, 1'b0, ak);
        check("rx ready", rx_byte_ready_flag, 1'b1);
        check("rx data", rx_data, exp);
        @(posedge mclk);
        rx_read <= 1'b1;
        @(posedge mclk);
        rx_read <= 1'b0;
        #1;
        check("rx ready cleared", rx_byte_ready_flag, 1'b0);
    endtask : read_byte
    task automatic stop_bus();
        do_byte(8'h00, 1'b0, 1'b1, 1'b0);
        check("released", {bus_owned, sda_oe, scl_oe}, 3'h0);
    endtask : stop_bus
    task automatic disabled_write();
        @(posedge mclk);
        start_request <= 1'b1;
        tx_data <= 8'ha0;
        tx_write <= 1'b1;
        @(posedge mclk);
        tx_write <= 1'b0;
        repeat (100) @(posedge mclk);
        #1;
        check("ignored write", {op_complete_flag, bus_owned, sda_oe, scl_oe}, 4'h8);
        // a stop with the bus still free must finish without touching the lines
        stop_bus();
    endtask : disabled_write
    task automatic page_write();
        @(posedge mclk);
        clock_divider_value <= 8'(i2c_master_defs::standard_min_div);
        do_byte({mem_addr, 1'b0}, 1'b1, 1'b0, 1'b0);
        check("address ack", {bus_owned, ack_received_flag}, 2'h3);
        do_byte(8'h10, 1'b0, 1'b0, 1'b0);
        check("word ack", ack_received_flag, 1'b1);
        do_byte(8'h3c, 1'b0, 1'b0, 1'b0);
        check("first data ack", ack_received_flag, 1'b1);
        do_byte(8'h5a, 1'b0, 1'b0, 1'b0);
        check("data ack", ack_received_flag, 1'b1);
        stop_bus();
        check("first byte", i_eeprom_slave_model.mem[8'h10], 8'h3c);
        check("second byte", i_eeprom_slave_model.mem[8'h11], 8'h5a);
        @(posedge mclk);
        clock_divider_value <= 8'(i2c_master_defs::fast_min_div);
    endtask : page_write
    task automatic nak_address();
        do_byte({7'h23, 1'b0}, 1'b1, 1'b0, 1'b0);
        check("no ack", ack_received_flag, 1'b0);
        stop_bus();
    endtask : nak_address
    task automatic random_read();
        do_byte({mem_addr, 1'b0}, 1'b1, 1'b0, 1'b0);
        do_byte(8'h10, 1'b0, 1'b0, 1'b0);
        do_byte({mem_addr, 1'b1}, 1'b1, 1'b0, 1'b0);
        check("repeated start", {bus_owned, ack_received_flag}, 2'h3);
        read_byte(8'h3c, 1'b0);
        check("single byte not acked", 8'(i_eeprom_slave_model.phase), 8'h04);
        stop_bus();
    endtask : random_read
    task automatic sequential_read();
        do_byte({mem_addr, 1'b1}, 1'b1, 1'b0, 1'b1);
        read_byte(8'h5a, 1'b1);
        check("acked byte", 8'(i_eeprom_slave_model.phase), 8'h03);
        read_byte(8'h12 ^ 8'ha5, 1'b1);
        read_byte(8'h13 ^ 8'ha5, 1'b0);
        check("last byte not acked", 8'(i_eeprom_slave_model.phase), 8'h04);
        stop_bus();
    endtask : sequential_read
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        check("reset state", {op_complete_flag, rx_byte_ready_flag, sda_oe, scl_oe}, 4'h8);
        disabled_write();
        page_write();
        nak_address();
        random_read();
        sequential_read();
        finish_test();
    end
endmodule : i2c_master_controller_tb
`default_nettype wire
